// *** hw/cmd_src_sel.sv ***
// Command source selector with droop enable and lifetime warning output
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "cmd_src_params.svh"
module cmd_src_sel #(
  parameter int FREQ_W  = 16,
  parameter int NUM_DI  = 7,
  parameter int NUM_DO  = 6,
  parameter int ADDR_W  = 4
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]            reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [31:0]                  reg_rdata_q,
  // Digital input terminals and their function assignments
  input  wire logic [NUM_DI-1:0]            di_level,
  input  wire logic [NUM_DI*`FUNC_CODE_W-1:0] di_func,
  // Digital output function assignments and outputs
  input  wire logic [NUM_DO*`FUNC_CODE_W-1:0] do_func,
  output logic      [NUM_DO-1:0]            do_level_q,
  // Life monitors
  input  wire logic                         life_near_end,
  // Frequency path
  input  wire logic [FREQ_W-1:0]            freq_local,
  input  wire logic [FREQ_W-1:0]            freq_port1,
  input  wire logic [FREQ_W-1:0]            freq_port2,
  input  wire logic [FREQ_W-1:0]            freq_fieldbus,
  input  wire logic [FREQ_W-1:0]            droop_offset,
  input  wire logic                         ramp_tick,
  // Run path
  input  wire logic                         run_keypad,
  input  wire logic                         run_terminal,
  input  wire logic                         run_port1,
  input  wire logic                         run_port2,
  input  wire logic                         run_fieldbus,
  // Resolved results
  output cmd_src_pkg::cmd_src_t             freq_src_q,
  output cmd_src_pkg::cmd_src_t             run_src_q,
  output logic                              link_enable_cmd_q,
  output logic                              droop_en_q,
  output logic      [FREQ_W-1:0]            freq_out_q,
  output logic                              run_out_q
);

  // ========================================================================
  // Register map
  localparam logic [ADDR_W-1:0] ADDR_SERIAL   = ADDR_W'(`OFS_SERIAL);
  localparam logic [ADDR_W-1:0] ADDR_FIELDBUS = ADDR_W'(`OFS_FIELDBUS);
  localparam logic [ADDR_W-1:0] ADDR_LOCAL    = ADDR_W'(`OFS_LOCAL);
  localparam logic [ADDR_W-1:0] ADDR_MODE     = ADDR_W'(`OFS_MODE);
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = ADDR_W'(`OFS_STATUS);
  localparam logic [ADDR_W-1:0] ADDR_STEP     = ADDR_W'(`OFS_STEP);

  // ========================================================================
  // Software settings
  logic [`SERIAL_CODE_W-1:0]   serial_link_source_sel_q;
  logic [`FIELDBUS_CODE_W-1:0] fieldbus_source_sel_q;
  logic                        freq_source_code_q;
  logic                        alt_freq_source_code_q;
  logic                        run_source_code_q;
  cmd_src_pkg::ctrl_mode_t     ctrl_mode_q;
  logic [FREQ_W-1:0]           ramp_step_q;

  wire wr_serial   = reg_wr && (reg_addr == ADDR_SERIAL);
  wire wr_fieldbus = reg_wr && (reg_addr == ADDR_FIELDBUS);
  wire wr_local    = reg_wr && (reg_addr == ADDR_LOCAL);
  wire wr_mode     = reg_wr && (reg_addr == ADDR_MODE);
  wire wr_step     = reg_wr && (reg_addr == ADDR_STEP);

  // Out-of-range serial codes are refused so the table never sees them
  wire serial_ok   = reg_wdata[`SERIAL_CODE_W-1:0] <= `SERIAL_CODE_MAX;
  // Code 3 names no control mode; refusing it keeps the ramp choice defined
  wire mode_ok     = reg_wdata[1:0] != `MODE_RESERVED;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      serial_link_source_sel_q <= `SERIAL_CODE_RST;
    end else if (wr_serial && serial_ok) begin
      serial_link_source_sel_q <= reg_wdata[`SERIAL_CODE_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fieldbus_source_sel_q <= `FIELDBUS_CODE_RST;
    end else if (wr_fieldbus) begin
      fieldbus_source_sel_q <= reg_wdata[`FIELDBUS_CODE_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      freq_source_code_q     <= 1'b0;
      alt_freq_source_code_q <= 1'b0;
      run_source_code_q      <= 1'b0;
    end else if (wr_local) begin
      freq_source_code_q     <= reg_wdata[0];
      alt_freq_source_code_q <= reg_wdata[1];
      run_source_code_q      <= reg_wdata[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_mode_q <= cmd_src_pkg::CTRL_VF;
    end else if (wr_mode && mode_ok) begin
      ctrl_mode_q <= cmd_src_pkg::ctrl_mode_t'(reg_wdata[1:0]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ramp_step_q <= FREQ_W'(`RAMP_STEP_RST);
    end else if (wr_step) begin
      ramp_step_q <= reg_wdata[FREQ_W-1:0];
    end
  end

  // ========================================================================
  // Terminal function decode
  function automatic logic func_active(
    input logic [NUM_DI-1:0]               lvl,
    input logic [NUM_DI*`FUNC_CODE_W-1:0]  funcs,
    input logic [`FUNC_CODE_W-1:0]         code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DI; i++) begin
      if (funcs[i*`FUNC_CODE_W +: `FUNC_CODE_W] == code && lvl[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic func_assigned(
    input logic [NUM_DI*`FUNC_CODE_W-1:0]  funcs,
    input logic [`FUNC_CODE_W-1:0]         code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DI; i++) begin
      if (funcs[i*`FUNC_CODE_W +: `FUNC_CODE_W] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  wire droop_on   = func_active(di_level, di_func, `FUNC_DROOP_SEL);
  wire link_on    = func_active(di_level, di_func, `FUNC_LINK_ENABLE);
  wire link_mapped = func_assigned(di_func, `FUNC_LINK_ENABLE);
  // Missing assignment counts as permanently enabled
  wire link_en    = link_mapped ? link_on : 1'b1;

  // ========================================================================
  // Source resolution
  cmd_src_pkg::cmd_src_t serial_freq_src;
  cmd_src_pkg::cmd_src_t serial_run_src;
  cmd_src_pkg::cmd_src_t freq_src_d;
  cmd_src_pkg::cmd_src_t run_src_d;

  // Serial-link table, frequency half
  function automatic cmd_src_pkg::cmd_src_t serial_freq_of(
    input logic [`SERIAL_CODE_W-1:0] code
  );
    unique case (code)
      4'h1, 4'h3, 4'h7: serial_freq_of = cmd_src_pkg::SRC_PORT1;
      4'h4, 4'h5, 4'h8: serial_freq_of = cmd_src_pkg::SRC_PORT2;
      default:          serial_freq_of = cmd_src_pkg::SRC_LOCAL;
    endcase
  endfunction

  // Serial-link table, run half
  function automatic cmd_src_pkg::cmd_src_t serial_run_of(
    input logic [`SERIAL_CODE_W-1:0] code
  );
    unique case (code)
      4'h2, 4'h3, 4'h5: serial_run_of = cmd_src_pkg::SRC_PORT1;
      4'h6, 4'h7, 4'h8: serial_run_of = cmd_src_pkg::SRC_PORT2;
      default:          serial_run_of = cmd_src_pkg::SRC_LOCAL;
    endcase
  endfunction

  // Port 1 is the keypad connector, port 2 the board line terminals
  assign serial_freq_src = serial_freq_of(serial_link_source_sel_q);
  assign serial_run_src  = serial_run_of(serial_link_source_sel_q);

  wire fb_freq = fieldbus_source_sel_q[0];
  wire fb_run  = fieldbus_source_sel_q[1];

  always_comb begin
    freq_src_d = cmd_src_pkg::SRC_LOCAL;
    run_src_d  = cmd_src_pkg::SRC_LOCAL;
    if (link_en) begin
      freq_src_d = fb_freq ? cmd_src_pkg::SRC_FIELDBUS : serial_freq_src;
      run_src_d  = fb_run  ? cmd_src_pkg::SRC_FIELDBUS : serial_run_src;
    end
  end

  // ========================================================================
  // Command muxing
  logic [FREQ_W-1:0] freq_sel;
  logic              run_sel;
  logic              run_local;

  assign run_local = run_source_code_q ? run_terminal : run_keypad;

  always_comb begin
    unique case (freq_src_q)
      cmd_src_pkg::SRC_PORT1:    freq_sel = freq_port1;
      cmd_src_pkg::SRC_PORT2:    freq_sel = freq_port2;
      cmd_src_pkg::SRC_FIELDBUS: freq_sel = freq_fieldbus;
      default:                   freq_sel = freq_local;
    endcase
    unique case (run_src_q)
      cmd_src_pkg::SRC_PORT1:    run_sel = run_port1;
      cmd_src_pkg::SRC_PORT2:    run_sel = run_port2;
      cmd_src_pkg::SRC_FIELDBUS: run_sel = run_fieldbus;
      default:                   run_sel = run_local;
    endcase
  end

  // ========================================================================
  // Droop compensation
  // Droop lowers the frequency; saturate at zero rather than wrap
  wire [FREQ_W-1:0] droop_sub  = droop_en_q ? droop_offset : '0;
  wire [FREQ_W-1:0] freq_droop = (freq_sel > droop_sub) ? FREQ_W'(freq_sel - droop_sub) : '0;
  wire              is_vf      = ctrl_mode_q == cmd_src_pkg::CTRL_VF;
  wire [FREQ_W-1:0] ramp_value;
  wire [FREQ_W-1:0] ramp_target = is_vf ? freq_droop : freq_sel;

  // Under V/f the ramp absorbs load steps, at the cost of lagging droop
  droop_ramp #(
    .FREQ_W (FREQ_W)
  ) u_ramp (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .step_en (ramp_tick),
    .step    (ramp_step_q),
    .target  (ramp_target),
    .value_q (ramp_value)
  );

  // Vector modes ramp the raw command and subtract droop after the ramp
  wire [FREQ_W-1:0] vec_out = (ramp_value > droop_sub) ?
                              FREQ_W'(ramp_value - droop_sub) : '0;
  wire [FREQ_W-1:0] freq_out_d = is_vf ? ramp_value : vec_out;

  // ========================================================================
  // Lifetime warning outputs
  logic [NUM_DO-1:0] do_level_d;

  genvar g;
  generate
    for (g = 0; g < NUM_DO; g++) begin : g_do
      assign do_level_d[g] =
        (do_func[g*`FUNC_CODE_W +: `FUNC_CODE_W] == `FUNC_LIFE_ALARM) && life_near_end;
    end
  endgenerate

  // ========================================================================
  // Registered results
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      freq_src_q <= cmd_src_pkg::SRC_LOCAL;
      run_src_q  <= cmd_src_pkg::SRC_LOCAL;
    end else begin
      freq_src_q <= freq_src_d;
      run_src_q  <= run_src_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      link_enable_cmd_q <= 1'b1;
      droop_en_q        <= 1'b0;
    end else begin
      link_enable_cmd_q <= link_en;
      droop_en_q        <= droop_on;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      freq_out_q <= '0;
      run_out_q  <= 1'b0;
      do_level_q <= '0;
    end else begin
      freq_out_q <= freq_out_d;
      run_out_q  <= run_sel;
      do_level_q <= do_level_d;
    end
  end

  // ========================================================================
  // Register read port
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      ADDR_SERIAL:   rd_mux[`SERIAL_CODE_W-1:0]   = serial_link_source_sel_q;
      ADDR_FIELDBUS: rd_mux[`FIELDBUS_CODE_W-1:0] = fieldbus_source_sel_q;
      ADDR_LOCAL:    rd_mux[2:0] = {run_source_code_q, alt_freq_source_code_q,
                                    freq_source_code_q};
      ADDR_MODE:     rd_mux[1:0] = ctrl_mode_q;
      ADDR_STATUS:   rd_mux[6:0] = {life_near_end, droop_en_q, link_enable_cmd_q,
                                    run_src_q, freq_src_q};
      ADDR_STEP:     rd_mux[FREQ_W-1:0] = ramp_step_q;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

endmodule

// *** hw/cmd_src_params.svh ***
// Constants for the command source selector: codes, field widths, reset values
`ifndef CMD_SRC_PARAMS_SVH
`define CMD_SRC_PARAMS_SVH

// ==========================================================================
// Terminal function numbers
`define FUNC_DROOP_SEL      8'h4C
`define FUNC_LINK_ENABLE    8'h18
`define FUNC_LIFE_ALARM     8'h00
`define FUNC_CODE_W         8

// ==========================================================================
// Code widths and limits
`define SERIAL_CODE_W       4
`define SERIAL_CODE_MAX     4'h8
`define FIELDBUS_CODE_W     2
`define SRC_SEL_W           2

// ==========================================================================
// Reset values
`define SERIAL_CODE_RST     4'h0
`define FIELDBUS_CODE_RST   2'h0
`define RAMP_STEP_RST       16'h0001

// ==========================================================================
// Register word offsets and refused codes
`define OFS_SERIAL          4'h0
`define OFS_FIELDBUS        4'h1
`define OFS_LOCAL           4'h2
`define OFS_MODE            4'h3
`define OFS_STATUS          4'h4
`define OFS_STEP            4'h5
`define MODE_RESERVED       2'h3

`endif

// *** hw/cmd_src_pkg.sv ***
// Types shared by the command source selector
package cmd_src_pkg;

  typedef enum logic [1:0] {
    SRC_LOCAL    = 2'h0,
    SRC_PORT1    = 2'h1,
    SRC_PORT2    = 2'h2,
    SRC_FIELDBUS = 2'h3
  } cmd_src_t;

  typedef enum logic [1:0] {
    CTRL_VF     = 2'h0,
    CTRL_VEC    = 2'h1,
    CTRL_VEC_PG = 2'h2
  } ctrl_mode_t;

endpackage

// *** hw/droop_ramp.sv ***
// Ramp limiter that slews the frequency command (droop-adjusted under V/f only) toward its target
`timescale 1ns/10ps
module droop_ramp #(
  parameter int FREQ_W = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              step_en,
  input  wire logic [FREQ_W-1:0] step,
  input  wire logic [FREQ_W-1:0] target,
  output logic      [FREQ_W-1:0] value_q
);

  logic [FREQ_W-1:0] value_d;
  logic [FREQ_W-1:0] diff_up;
  logic [FREQ_W-1:0] diff_dn;
  logic              go_up;

  assign go_up   = target > value_q;
  assign diff_up = target - value_q;
  assign diff_dn = value_q - target;

  // Clamp the last step so the ramp lands on the target without overshoot
  always_comb begin
    value_d = value_q;
    if (step_en) begin
      if (go_up) begin
        value_d = (diff_up > step) ? FREQ_W'(value_q + step) : target;
      end else begin
        value_d = (diff_dn > step) ? FREQ_W'(value_q - step) : target;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      value_q <= '0;
    end else begin
      value_q <= value_d;
    end
  end

endmodule

// *** tb/cmd_src_sel_monitor.sv ***
// Assertion checker for the command source selector
`timescale 1ns/10ps
`include "cmd_src_params.svh"
module cmd_src_sel_checker #(
  parameter int NUM_DI = 7,
  parameter int NUM_DO = 6,
  parameter int ADDR_W = 4
) (
  input wire logic                           ref_clk,
  input wire logic                           rst_n,
  input wire logic [ADDR_W-1:0]              reg_addr,
  input wire logic                           reg_wr,
  input wire logic                           reg_rd,
  input wire logic [31:0]                    reg_rdata_q,
  input wire logic [NUM_DI-1:0]              di_level,
  input wire logic [NUM_DI*`FUNC_CODE_W-1:0] di_func,
  input wire logic [NUM_DO*`FUNC_CODE_W-1:0] do_func,
  input wire logic [NUM_DO-1:0]              do_level_q,
  input wire logic                           life_near_end,
  input wire logic                           run_port1,
  input wire logic                           run_port2,
  input wire logic                           run_fieldbus,
  input wire cmd_src_pkg::cmd_src_t          freq_src_q,
  input wire cmd_src_pkg::cmd_src_t          run_src_q,
  input wire logic                           link_enable_cmd_q,
  input wire logic                           droop_en_q,
  input wire logic                           run_out_q
);
  // ====
  // Terminal decode
  logic              droop_on;
  logic              link_asg;
  logic              link_any;
  logic              link_on;
  logic              run_sel;
  logic [NUM_DO-1:0] life_mask;
  always_comb begin
    droop_on = 1'b0;
    link_asg = 1'b0;
    link_any = 1'b0;
    for (int i = 0; i < NUM_DI; i++) begin
      if (di_func[i*`FUNC_CODE_W +: `FUNC_CODE_W] == `FUNC_DROOP_SEL) begin
        droop_on = droop_on | di_level[i];
      end
      if (di_func[i*`FUNC_CODE_W +: `FUNC_CODE_W] == `FUNC_LINK_ENABLE) begin
        link_asg = 1'b1;
        link_any = link_any | di_level[i];
      end
    end
    for (int g = 0; g < NUM_DO; g++) begin
      life_mask[g] = do_func[g*`FUNC_CODE_W +: `FUNC_CODE_W] == `FUNC_LIFE_ALARM;
    end
  end
  // An unassigned link enable counts as permanently on
  assign link_on = !link_asg || link_any;
  assign run_sel = (run_src_q == cmd_src_pkg::SRC_PORT1) ? run_port1 :
                   (run_src_q == cmd_src_pkg::SRC_PORT2) ? run_port2 : run_fieldbus;
  // ====
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  droop_follow_a: assert property (1'b1 |=> droop_en_q == $past(droop_on))
    else $error("droop enable does not follow its terminal");
  link_follow_a: assert property (1'b1 |=> link_enable_cmd_q == $past(link_on))
    else $error("link enable does not follow its terminal");
  local_force_a: assert property (
    !link_on |=> freq_src_q == cmd_src_pkg::SRC_LOCAL && run_src_q == cmd_src_pkg::SRC_LOCAL)
    else $error("link off did not force local sources");
  bus_needs_link_a: assert property (
    freq_src_q == cmd_src_pkg::SRC_FIELDBUS || run_src_q == cmd_src_pkg::SRC_FIELDBUS
    |-> $past(link_on))
    else $error("fieldbus source chosen with link off");
  life_warn_a: assert property (
    1'b1 |=> do_level_q == ({NUM_DO{$past(life_near_end)}} & $past(life_mask)))
    else $error("lifetime output does not follow the monitors");
  run_pick_a: assert property (
    run_src_q != cmd_src_pkg::SRC_LOCAL |=> run_out_q == $past(run_sel))
    else $error("run command not taken from the selected link");
  status_read_a: assert property (
    reg_rd && reg_addr == ADDR_W'(4) |=> reg_rdata_q[5:0] ==
    {$past(droop_en_q), $past(link_enable_cmd_q), $past(run_src_q), $past(freq_src_q)})
    else $error("status read disagrees with the resolved outputs");
  src_hold_a: assert property (
    $past(rst_n) && $past(rst_n, 2) && !$past(reg_wr) && !$past(reg_wr, 2)
    && $past(di_level) == $past(di_level, 2) && $past(di_func) == $past(di_func, 2)
    |-> $stable(freq_src_q) && $stable(run_src_q))
    else $error("sources moved without a cause");
  cov_bus_c: cover property (freq_src_q == cmd_src_pkg::SRC_FIELDBUS);
  cov_link_off_c: cover property (!link_enable_cmd_q);
  cov_droop_c: cover property ($rose(droop_en_q));
endmodule

bind cmd_src_sel cmd_src_sel_checker #(
  .NUM_DI(NUM_DI), .NUM_DO(NUM_DO), .ADDR_W(ADDR_W)
) u_chk (
  .ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata_q, .di_level, .di_func,
  .do_func, .do_level_q, .life_near_end, .run_port1, .run_port2, .run_fieldbus,
  .freq_src_q, .run_src_q, .link_enable_cmd_q, .droop_en_q, .run_out_q
);

// *** tb/remote_host_model.sv ***
// Remote host model: frequency and run commands arriving over the links
`timescale 1ns/10ps
module remote_host_model #(
  parameter int FREQ_W = 16,
  parameter bit SLOW   = 1'b1
) (
  input  wire logic              ref_clk,
  input  wire logic [2:0]        run_pat,
  output logic      [FREQ_W-1:0] freq_port1,
  output logic      [FREQ_W-1:0] freq_port2,
  output logic      [FREQ_W-1:0] freq_fieldbus,
  output logic                   run_port1,
  output logic                   run_port2,
  output logic                   run_fieldbus
);
  // ====
  // Link commands
  logic [2:0] pat_q;
  always_ff @(posedge ref_clk) begin
    pat_q <= run_pat;
  end
  // A slow host lands each run command one control cycle late
  assign run_port1     = SLOW ? pat_q[0] : run_pat[0];
  assign run_port2     = SLOW ? pat_q[1] : run_pat[1];
  assign run_fieldbus  = SLOW ? pat_q[2] : run_pat[2];
  assign freq_port1    = FREQ_W'(16'h1111);
  assign freq_port2    = FREQ_W'(16'h2222);
  assign freq_fieldbus = FREQ_W'(16'h4444);
endmodule

// *** tb/cmd_src_sel_test.sv ***
// Self-checking bench for the command source selector
`timescale 1ns/10ps
module cmd_src_sel_test;
  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [3:0]            reg_addr = 4'h0;
  logic [31:0]           reg_wdata = 32'h0;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [31:0]           reg_rdata_q;
  logic [6:0]            di_level = 7'h00;
  logic [55:0]           di_func = {7{8'hFF}};
  logic [47:0]           do_func = {6{8'hFF}};
  logic [5:0]            do_level_q;
  logic                  life_near_end = 1'b0;
  logic [15:0]           freq_local = 16'h3000;
  logic [15:0]           freq_port1;
  logic [15:0]           freq_port2;
  logic [15:0]           freq_fieldbus;
  logic [15:0]           droop_offset = 16'h0100;
  logic                  ramp_tick = 1'b1;
  logic                  run_keypad = 1'b0;
  logic                  run_terminal = 1'b0;
  logic                  run_port1;
  logic                  run_port2;
  logic                  run_fieldbus;
  logic [2:0]            run_pat = 3'h0;
  cmd_src_pkg::cmd_src_t freq_src_q;
  cmd_src_pkg::cmd_src_t run_src_q;
  logic                  link_enable_cmd_q;
  logic                  droop_en_q;
  logic [15:0]           freq_out_q;
  logic                  run_out_q;
  logic [1:0]            ef;
  logic [1:0]            er;
  logic [1:0]            ftab [0:8] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h2};
  logic [1:0]            rtab [0:8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
  int                    n_errors = 0;
  int                    checks_done = 0;

  always #5 ref_clk = ~ref_clk;
  cmd_src_sel DUT (
    .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .di_level,
    .di_func, .do_func, .do_level_q, .life_near_end, .freq_local, .freq_port1, .freq_port2,
    .freq_fieldbus, .droop_offset, .ramp_tick, .run_keypad, .run_terminal, .run_port1,
    .run_port2, .run_fieldbus, .freq_src_q, .run_src_q, .link_enable_cmd_q, .droop_en_q,
    .freq_out_q, .run_out_q
  );
  remote_host_model host (
    .ref_clk, .run_pat, .freq_port1, .freq_port2, .freq_fieldbus, .run_port1, .run_port2,
    .run_fieldbus
  );

  // ====
  // Bus and check tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata_q, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ====
  // Scenarios
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(4'h4, 32'h10);
    rd(4'h5, 32'h1);
    rd(4'hF, 32'h0);
    wr(4'h0, 32'h3);
    wr(4'h0, 32'h9);
    rd(4'h0, 32'h3);
    for (int s = 0; s < 9; s++) begin
      for (int f = 0; f < 4; f++) begin
        @(posedge ref_clk);
        run_pat <= 3'(s + f);
        run_keypad <= s[0];
        wr(4'h0, 32'(s));
        wr(4'h1, 32'(f));
        settle(3);
        ef = f[0] ? 2'h3 : ftab[s];
        er = f[1] ? 2'h3 : rtab[s];
        check(freq_src_q, ef);
        check(run_src_q, er);
        if (er != 2'h0) begin
          check(run_out_q, run_pat[er - 2'h1]);
        end else begin
          check(run_out_q, run_keypad);
        end
      end
    end
    // Link enable on input 2, droop select on input 0
    @(posedge ref_clk) di_func <= {{4{8'hFF}}, 8'h18, 8'hFF, 8'h4C};
    settle(2);
    check(link_enable_cmd_q, 1'b0);
    check({freq_src_q, run_src_q}, 4'h0);
    @(posedge ref_clk) di_level <= 7'h04;
    settle(2);
    check({freq_src_q, run_src_q}, 4'hF);
    rd(4'h4, 32'h1F);
    @(posedge ref_clk) di_level <= 7'h00;
    @(posedge ref_clk) do_func <= {{4{8'hFF}}, 8'h00, 8'hFF};
    life_near_end <= 1'b1;
    settle(2);
    check(do_level_q, 6'h02);
    @(posedge ref_clk) life_near_end <= 1'b0;
    settle(2);
    check(do_level_q, 6'h00);
    // Both vector modes first, then V/f; a slow step shows whether droop waits for the ramp
    for (int m = 2; m >= 0; m--) begin
      wr(4'h3, 32'(m));
      wr(4'h5, 32'h1000);
      settle(8);
      check(freq_out_q, 16'h3000);
      wr(4'h5, 32'h1);
      @(posedge ref_clk) di_level <= 7'h01;
      settle(4);
      check(droop_en_q, 1'b1);
      // V/f output has slewed only two steps of 1 toward the drooped target by now
      check(freq_out_q, (m != 0) ? 16'h2F00 : 16'h2FFE);
      @(posedge ref_clk) di_level <= 7'h00;
      settle(2);
      check(droop_en_q, 1'b0);
    end
    wr(4'h3, 32'h3);
    rd(4'h3, 32'h0);
    wr(4'h2, 32'h7);
    rd(4'h2, 32'h7);
    @(posedge ref_clk) run_terminal <= 1'b1;
    settle(2);
    check(run_out_q, 1'b1);
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    complete_run();
  end
endmodule
